// ### hdl/grb_defines.svh
// register offsets, field positions and reset values of the gauge register bank
`ifndef GRB_DEFINES_SVH
`define GRB_DEFINES_SVH
// byte addresses, the high byte of a pair sits at the lower one
`define GRB_A_MODE 8'h00
`define GRB_A_CTRL 8'h01
`define GRB_A_SOC 8'h02
`define GRB_A_COUNT 8'h04
`define GRB_A_CURRENT 8'h06
`define GRB_A_VOLTAGE 8'h08
`define GRB_A_TEMP 8'h0a
`define GRB_A_CC_ADJ_HI 8'h0b
`define GRB_A_VM_ADJ_HI 8'h0c
`define GRB_A_OPEN_CIRCUIT 8'h0d
`define GRB_A_CC_CNF 8'h0f
`define GRB_A_VM_CNF 8'h11
`define GRB_A_CHG_LEVEL 8'h13
`define GRB_A_VOLT_LEVEL 8'h14
`define GRB_A_RELAX_THR 8'h15
`define GRB_A_RELAX_CNT 8'h16
`define GRB_A_RELAX_LIM 8'h17
`define GRB_A_PART 8'h18
`define GRB_A_CC_ADJ_LO 8'h19
`define GRB_A_VM_ADJ_LO 8'h1a
`define GRB_A_ACC_CC 8'h1b
`define GRB_A_ACC_VM 8'h1d
`define GRB_A_MAP_END 8'h1e
`define GRB_A_RAM 8'h20
`define GRB_A_TAB 8'h30
`define GRB_A_TAB_END 8'h3f
// mode field positions
`define GRB_M_METHOD 0
`define GRB_M_CLR_VM 1
`define GRB_M_CLR_CC 2
`define GRB_M_ALARM_EN 3
`define GRB_M_OPERATE 4
`define GRB_M_FORCE_COUNTING_METHOD 5
`define GRB_M_FORCE_VOLTAGE_METHOD 6
// control field positions
`define GRB_C_DRIVE 0
`define GRB_C_CNT_CLR 1
`define GRB_C_BAT 3
`define GRB_C_POR 4
`define GRB_C_CHG_ALARM 5
`define GRB_C_VOLT_ALARM 6
// reset values
`define GRB_MODE_RST 7'h09
`define GRB_CC_CNF_RST 16'h018b
`define GRB_VM_CNF_RST 16'h0141
`define GRB_CHG_LEVEL_RST 8'h02
`define GRB_VOLT_LEVEL_RST 8'haa
`define GRB_RELAX_THR_RST 8'h0a
`define GRB_RELAX_RST 8'h78
`endif

// ### hdl/grb_pkg.sv
// types shared by the gauge register bank and its neighbours
package grb_pkg;
  // byte strobes from the serial slave front end
  typedef struct packed {
    logic start;
    logic addr_we;
    logic wr_we;
    logic rd_re;
    logic [7:0] data;
  } grb_req_t;
  // results from the gauging datapath
  typedef struct packed {
    logic update;
    logic vm_active;
    logic [15:0] soc;
    logic [15:0] current;
    logic [15:0] voltage;
    logic [7:0] temp;
    logic [7:0] relax;
  } grb_meas_t;
  // mode controls to the datapath
  typedef struct packed {
    logic power_saving_method_sel;
    logic gauge_operate;
    logic alarm_function_enable;
    logic force_counting_method;
    logic force_voltage_method;
    logic conversion_count_clear;
  } grb_ctl_t;
  // configuration to the datapath
  typedef struct packed {
    logic [15:0] open_circuit_voltage;
    logic [15:0] cc_cnf;
    logic [15:0] vm_cnf;
    logic [7:0] charge_level;
    logic [7:0] volt_level;
    logic [7:0] relax_thr;
    logic [7:0] relax_limit;
  } grb_cfg_t;
endpackage

// ### hdl/grb_alarm.sv
// one sticky alarm flag, armed on a fresh rising condition
`timescale 1ns/10ps
module grb_alarm
(
  input logic clock,
  input logic rstn,
  input logic srst,
  input logic cond,
  input logic arm,
  input logic clr,
  output logic flag
);
  logic cond_q; // condition one cycle ago
  logic rise; // condition newly seen
  assign rise = cond && !cond_q;
  // condition history, so a cleared flag waits for a new edge
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cond_q <= 1'b0;
    else
      cond_q <= cond;
  end
  // set wins over the software clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      flag <= 1'b0;
    else if (srst)
      flag <= 1'b0;
    else if (rise && arm)
      flag <= 1'b1; // RULE_18 RULE_19
    else if (clr)
      flag <= 1'b0;
  end
  a_flag_set: assert property (@(posedge clock) disable iff (!rstn) rise && arm && !srst |=> flag) // RULE_18
    else $error("alarm flag not set");
endmodule

// ### hdl/grb_ram.sv
// sixteen working bytes with no reset
`timescale 1ns/10ps
module grb_ram
(
  input logic clock,
  input logic we,
  input logic [3:0] addr,
  input logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [16]; // contents survive soft reset
  // plain write port
  always_ff @(posedge clock)
  begin
    if (we)
      mem[addr] <= wdata; // RULE_20
  end
  assign rdata = mem[addr];
  a_ram_keep: assert property (@(posedge clock) $past(we) |-> mem[$past(addr)] == $past(wdata)) // RULE_20
    else $error("ram byte lost");
endmodule

// ### hdl/grb_bank.sv
// gauge register bank: byte registers behind the serial slave port
//
// Functional notes
// RULE_01: reset loads defaults, flags power-on event
// RULE_02: high byte at lower address
// RULE_03: host reads pairs in one transaction
// RULE_04: charge unsigned, 1/512 percent per bit
// RULE_05: current two's complement, 5.88 uV steps
// RULE_06: voltage two's complement, 2.20 mV steps
// RULE_07: temperature one signed byte, 1 C steps
// RULE_08: mode bit 0 picks method, default voltage
// RULE_09: clear bits zero correction; self clear running
// RULE_10: mode bit 4 low freezes gauging
// RULE_11: force counting clears relax counter, self clears
// RULE_12: force voltage loads relax limit, self clears
// RULE_13: control bit 0 reads pin, drives low
// RULE_14: control bit 1 clears conversion count
// RULE_15: control bit 2 reports active method
// RULE_16: battery loss flag, cleared writing zero
// RULE_17: power-on flag and soft reset bit
// RULE_18: low charge flag sticky until zero written
// RULE_19: low voltage flag sticky until zero written
// RULE_20: working ram survives soft reset
// RULE_21: voltage alarm level defaults to aa
// RULE_22: relax threshold, counter and limit defaults
// RULE_23: sixteen table bytes reset to zero
// RULE_24: fixed part code at address 24
// RULE_25: pin held low until both flags cleared
// RULE_26: alarm enable set after reset
// RULE_27: address byte selects the register
// RULE_28: address steps after each data byte
// RULE_29: unmapped reads zero, writes ignored
`timescale 1ns/10ps
`include "grb_defines.svh"
module grb_bank
#(
  parameter logic [7:0] PART_CODE = 8'h5a // arbitrary value
)
(
  input logic clock,
  input logic rstn,
  input grb_pkg::grb_req_t bus_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input grb_pkg::grb_meas_t meas,
  input logic low_charge_cond,
  input logic low_voltage_cond,
  input logic battery_loss_evt,
  input logic alarm_pin_i,
  output logic alarm_pin_o,
  output logic alarm_pin_oe,
  output grb_pkg::grb_ctl_t gauge_ctl,
  output grb_pkg::grb_cfg_t gauge_cfg
);
  logic [7:0] ptr_r; // register pointer
  logic [7:0] wd; // write byte
  logic srst; // soft reset request
  logic [6:0] mode_r; // mode bits
  logic drive_r; // pin release, zero pulls the pin low
  logic bat_r; // battery loss flag
  logic por_r; // power-on flag
  logic cclr_r; // count clear pulse
  logic chg_flag; // low charge flag
  logic volt_flag; // low voltage flag
  logic operate; // gauging running
  logic [15:0] soc_r; // live charge
  logic [15:0] cnt_r; // conversions
  logic [15:0] cur_r; // current result
  logic [15:0] vlt_r; // voltage result
  logic [7:0] temp_r; // temperature
  logic [7:0] relax_r; // relax counter
  logic vm_r; // method in use
  logic [15:0] soc_s; // snapshots for the transaction
  logic [15:0] cnt_s;
  logic [15:0] cur_s;
  logic [15:0] vlt_s;
  logic [7:0] temp_s;
  logic [7:0] relax_s;
  logic vm_s;
  logic [7:0] cc_adj_hi_r; // correction factors
  logic [7:0] cc_adj_lo_r;
  logic [7:0] vm_adj_hi_r;
  logic [7:0] vm_adj_lo_r;
  logic [15:0] acc_cc_r; // correction accumulators
  logic [15:0] acc_vm_r;
  logic [15:0] ocv_val_r; // open circuit value
  logic [15:0] cc_cnf_r; // configuration words
  logic [15:0] vm_cnf_r;
  logic [7:0] chg_lvl_r; // alarm levels
  logic [7:0] volt_lvl_r;
  logic [7:0] relax_thr_r; // relax settings
  logic [7:0] relax_lim_r;
  logic [7:0] tab_r [16]; // adjustment table
  logic [7:0] ram_rdata; // working ram byte
  logic ram_we; // working ram write

  assign wd = bus_req.data;
  assign operate = mode_r[`GRB_M_OPERATE];

  // write strobe aimed at one address
  function automatic logic wr_at(input logic [7:0] a);
    return bus_req.wr_we && (ptr_r == a);
  endfunction

  // address decode used by the read path and its assertion
  function automatic logic is_mapped(input logic [7:0] a);
    return (a <= `GRB_A_MAP_END) || ((a >= `GRB_A_RAM) && (a <= `GRB_A_TAB_END));
  endfunction

  assign srst = wr_at(`GRB_A_CTRL) && wd[`GRB_C_POR]; // RULE_17
  assign ram_we = bus_req.wr_we && (ptr_r >= `GRB_A_RAM) && (ptr_r < `GRB_A_TAB);

  // pointer loads from the address byte, then steps per data byte
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ptr_r <= 8'h00;
    else if (bus_req.addr_we)
      ptr_r <= bus_req.data; // RULE_27
    else if (bus_req.wr_we || bus_req.rd_re)
      ptr_r <= ptr_r + 8'h01; // RULE_28
  end

  // mode bits; force strobes fall back to zero on their own, clear bits only while gauging runs
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mode_r <= `GRB_MODE_RST; // RULE_01 RULE_08 RULE_26
    else if (srst)
      mode_r <= `GRB_MODE_RST;
    else if (wr_at(`GRB_A_MODE))
      mode_r <= wd[6:0]; // RULE_29
    else
    begin
      if (operate)
      begin
        mode_r[`GRB_M_CLR_VM] <= 1'b0; // RULE_09
        mode_r[`GRB_M_CLR_CC] <= 1'b0;
      end
      mode_r[`GRB_M_FORCE_COUNTING_METHOD] <= 1'b0; // RULE_11
      mode_r[`GRB_M_FORCE_VOLTAGE_METHOD] <= 1'b0; // RULE_12
    end
  end

  // control bits written by software
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_r <= 1'b1;
      por_r <= 1'b1; // RULE_01
      cclr_r <= 1'b0;
    end
    else if (srst)
    begin
      drive_r <= 1'b1;
      por_r <= 1'b1; // RULE_17
      cclr_r <= 1'b0;
    end
    else if (wr_at(`GRB_A_CTRL))
    begin
      drive_r <= wd[`GRB_C_DRIVE]; // RULE_13
      por_r <= 1'b0; // RULE_17
      cclr_r <= wd[`GRB_C_CNT_CLR]; // RULE_14
    end
    else
      cclr_r <= 1'b0;
  end

  // battery loss flag, event wins over the clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      bat_r <= 1'b0;
    else if (srst)
      bat_r <= 1'b0;
    else if (battery_loss_evt)
      bat_r <= 1'b1; // RULE_16
    else if (wr_at(`GRB_A_CTRL) && !wd[`GRB_C_BAT])
      bat_r <= 1'b0; // RULE_16
  end

  // conversion count, frozen in standby
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= 16'h0000;
    else if (srst || (wr_at(`GRB_A_CTRL) && wd[`GRB_C_CNT_CLR]))
      cnt_r <= 16'h0000; // RULE_14
    else if (meas.update && operate)
      cnt_r <= cnt_r + 16'h0001; // RULE_10
  end

  // measurement results taken from the datapath while running
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_r <= 16'h0000;
      vlt_r <= 16'h0000;
      temp_r <= 8'h00;
      vm_r <= 1'b0;
    end
    else if (srst)
    begin
      cur_r <= 16'h0000;
      vlt_r <= 16'h0000;
      temp_r <= 8'h00;
      vm_r <= 1'b0;
    end
    else if (meas.update && operate)
    begin
      cur_r <= meas.current; // RULE_05 RULE_10
      vlt_r <= meas.voltage; // RULE_06
      temp_r <= meas.temp; // RULE_07
      vm_r <= meas.vm_active; // RULE_15
    end
  end

  // charge value: host may write it, datapath refreshes it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      soc_r <= 16'h0000;
    else if (srst)
      soc_r <= 16'h0000;
    else if (wr_at(`GRB_A_SOC))
      soc_r[15:8] <= wd; // RULE_02
    else if (wr_at(`GRB_A_SOC + 8'h01))
      soc_r[7:0] <= wd;
    else if (meas.update && operate)
      soc_r <= meas.soc; // RULE_04
  end

  // relax counter, forced by the mode strobes
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      relax_r <= `GRB_RELAX_RST; // RULE_22
    else if (srst)
      relax_r <= `GRB_RELAX_RST;
    else if (mode_r[`GRB_M_FORCE_COUNTING_METHOD])
      relax_r <= 8'h00; // RULE_11
    else if (mode_r[`GRB_M_FORCE_VOLTAGE_METHOD])
      relax_r <= relax_lim_r; // RULE_12
    else if (meas.update && operate)
      relax_r <= meas.relax;
  end

  // snapshot at transaction start keeps multi-byte reads coherent
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      soc_s <= 16'h0000;
      cnt_s <= 16'h0000;
      cur_s <= 16'h0000;
      vlt_s <= 16'h0000;
      temp_s <= 8'h00;
      relax_s <= `GRB_RELAX_RST;
      vm_s <= 1'b0;
    end
    else if (bus_req.start)
    begin
      soc_s <= soc_r; // RULE_03
      cnt_s <= cnt_r;
      cur_s <= cur_r;
      vlt_s <= vlt_r;
      temp_s <= temp_r;
      relax_s <= relax_r;
      vm_s <= vm_r;
    end
  end

  // correction factors and accumulators; clear bits take priority
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cc_adj_hi_r <= 8'h00;
      cc_adj_lo_r <= 8'h00;
      acc_cc_r <= 16'h0000;
    end
    else if (srst || mode_r[`GRB_M_CLR_CC])
    begin
      cc_adj_hi_r <= 8'h00; // RULE_09
      cc_adj_lo_r <= 8'h00;
      acc_cc_r <= 16'h0000;
    end
    else
    begin
      if (wr_at(`GRB_A_CC_ADJ_HI))
        cc_adj_hi_r <= wd;
      if (wr_at(`GRB_A_CC_ADJ_LO))
        cc_adj_lo_r <= wd;
      if (wr_at(`GRB_A_ACC_CC))
        acc_cc_r[15:8] <= wd; // RULE_02
      if (wr_at(`GRB_A_ACC_CC + 8'h01))
        acc_cc_r[7:0] <= wd;
    end
  end

  // voltage-mode side of the corrections
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      vm_adj_hi_r <= 8'h00;
      vm_adj_lo_r <= 8'h00;
      acc_vm_r <= 16'h0000;
    end
    else if (srst || mode_r[`GRB_M_CLR_VM])
    begin
      vm_adj_hi_r <= 8'h00; // RULE_09
      vm_adj_lo_r <= 8'h00;
      acc_vm_r <= 16'h0000;
    end
    else
    begin
      if (wr_at(`GRB_A_VM_ADJ_HI))
        vm_adj_hi_r <= wd;
      if (wr_at(`GRB_A_VM_ADJ_LO))
        vm_adj_lo_r <= wd;
      if (wr_at(`GRB_A_ACC_VM))
        acc_vm_r[15:8] <= wd;
      if (wr_at(`GRB_A_ACC_VM + 8'h01))
        acc_vm_r[7:0] <= wd;
    end
  end

  // configuration words and thresholds
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ocv_val_r <= 16'h0000;
      cc_cnf_r <= `GRB_CC_CNF_RST;
      vm_cnf_r <= `GRB_VM_CNF_RST;
      chg_lvl_r <= `GRB_CHG_LEVEL_RST;
      volt_lvl_r <= `GRB_VOLT_LEVEL_RST; // RULE_21
      relax_thr_r <= `GRB_RELAX_THR_RST; // RULE_22
      relax_lim_r <= `GRB_RELAX_RST;
    end
    // soft reset restores the same defaults, synchronously
    else if (srst)
    begin
      ocv_val_r <= 16'h0000;
      cc_cnf_r <= `GRB_CC_CNF_RST;
      vm_cnf_r <= `GRB_VM_CNF_RST;
      chg_lvl_r <= `GRB_CHG_LEVEL_RST;
      volt_lvl_r <= `GRB_VOLT_LEVEL_RST;
      relax_thr_r <= `GRB_RELAX_THR_RST;
      relax_lim_r <= `GRB_RELAX_RST;
    end
    else
    begin
      if (wr_at(`GRB_A_OPEN_CIRCUIT))
        ocv_val_r[15:8] <= wd;
      if (wr_at(`GRB_A_OPEN_CIRCUIT + 8'h01))
        ocv_val_r[7:0] <= wd;
      if (wr_at(`GRB_A_CC_CNF))
        cc_cnf_r[15:8] <= wd;
      if (wr_at(`GRB_A_CC_CNF + 8'h01))
        cc_cnf_r[7:0] <= wd;
      if (wr_at(`GRB_A_VM_CNF))
        vm_cnf_r[15:8] <= wd;
      if (wr_at(`GRB_A_VM_CNF + 8'h01))
        vm_cnf_r[7:0] <= wd;
      if (wr_at(`GRB_A_CHG_LEVEL))
        chg_lvl_r <= wd;
      if (wr_at(`GRB_A_VOLT_LEVEL))
        volt_lvl_r <= wd;
      if (wr_at(`GRB_A_RELAX_THR))
        relax_thr_r <= wd;
      if (wr_at(`GRB_A_RELAX_LIM))
        relax_lim_r <= wd;
    end
  end

  // adjustment table, cleared by either reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 16; i++)
        tab_r[i] <= 8'h00; // RULE_23
    end
    else if (srst)
    begin
      for (int i = 0; i < 16; i++)
        tab_r[i] <= 8'h00;
    end
    else if (bus_req.wr_we && (ptr_r >= `GRB_A_TAB) && (ptr_r <= `GRB_A_TAB_END))
      tab_r[ptr_r[3:0]] <= wd;
  end

  // read mux, pairs give the high byte first
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (!is_mapped(a))
      v = 8'h00; // RULE_29
    else if (a >= `GRB_A_TAB)
      v = tab_r[a[3:0]];
    else if (a >= `GRB_A_RAM)
      v = ram_rdata; // RULE_20
    else
      unique case (a)
        `GRB_A_MODE: v = {1'b0, mode_r}; // RULE_29
        `GRB_A_CTRL: v = {1'b0, volt_flag, chg_flag, por_r, bat_r, vm_s, 1'b0, alarm_pin_i}; // RULE_13 RULE_15
        `GRB_A_SOC: v = soc_s[15:8]; // RULE_02 RULE_04
        8'h03: v = soc_s[7:0];
        `GRB_A_COUNT: v = cnt_s[15:8];
        8'h05: v = cnt_s[7:0];
        `GRB_A_CURRENT: v = cur_s[15:8]; // RULE_05
        8'h07: v = cur_s[7:0];
        `GRB_A_VOLTAGE: v = vlt_s[15:8]; // RULE_06
        8'h09: v = vlt_s[7:0];
        `GRB_A_TEMP: v = temp_s; // RULE_07
        `GRB_A_CC_ADJ_HI: v = cc_adj_hi_r;
        `GRB_A_VM_ADJ_HI: v = vm_adj_hi_r;
        `GRB_A_OPEN_CIRCUIT: v = ocv_val_r[15:8];
        8'h0e: v = ocv_val_r[7:0];
        `GRB_A_CC_CNF: v = cc_cnf_r[15:8];
        8'h10: v = cc_cnf_r[7:0];
        `GRB_A_VM_CNF: v = vm_cnf_r[15:8];
        8'h12: v = vm_cnf_r[7:0];
        `GRB_A_CHG_LEVEL: v = chg_lvl_r;
        `GRB_A_VOLT_LEVEL: v = volt_lvl_r;
        `GRB_A_RELAX_THR: v = relax_thr_r;
        `GRB_A_RELAX_CNT: v = relax_s; // RULE_22
        `GRB_A_RELAX_LIM: v = relax_lim_r;
        `GRB_A_PART: v = PART_CODE; // RULE_24
        `GRB_A_CC_ADJ_LO: v = cc_adj_lo_r;
        `GRB_A_VM_ADJ_LO: v = vm_adj_lo_r;
        `GRB_A_ACC_CC: v = acc_cc_r[15:8];
        8'h1c: v = acc_cc_r[7:0];
        `GRB_A_ACC_VM: v = acc_vm_r[15:8];
        8'h1e: v = acc_vm_r[7:0];
        default: v = 8'h00;
      endcase
    return v;
  endfunction

  // read answer registered one cycle after the request
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= bus_req.rd_re;
      if (bus_req.rd_re)
        rd_data <= read_byte(ptr_r);
    end
  end

  // alarm pin pulled low by software or by a latched flag
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      alarm_pin_oe <= 1'b0;
    else
      alarm_pin_oe <= !drive_r || chg_flag || volt_flag; // RULE_13 RULE_25
  end
  assign alarm_pin_o = 1'b0;

  grb_alarm u_chg_alarm
  (
    .clock(clock),
    .rstn(rstn),
    .srst(srst),
    .cond(low_charge_cond),
    .arm(mode_r[`GRB_M_ALARM_EN] && operate),
    .clr(wr_at(`GRB_A_CTRL) && !wd[`GRB_C_CHG_ALARM]),
    .flag(chg_flag)
  );

  grb_alarm u_volt_alarm
  (
    .clock(clock),
    .rstn(rstn),
    .srst(srst),
    .cond(low_voltage_cond),
    .arm(mode_r[`GRB_M_ALARM_EN] && operate),
    .clr(wr_at(`GRB_A_CTRL) && !wd[`GRB_C_VOLT_ALARM]),
    .flag(volt_flag)
  );

  grb_ram u_ram
  (
    .clock(clock),
    .we(ram_we),
    .addr(ptr_r[3:0]),
    .wdata(wd),
    .rdata(ram_rdata)
  );

  // outputs to the datapath, all from flops
  assign gauge_ctl = {mode_r[`GRB_M_METHOD], operate, mode_r[`GRB_M_ALARM_EN],
                      mode_r[`GRB_M_FORCE_COUNTING_METHOD], mode_r[`GRB_M_FORCE_VOLTAGE_METHOD], cclr_r};
  assign gauge_cfg = {ocv_val_r, cc_cnf_r, vm_cnf_r, chg_lvl_r, volt_lvl_r, relax_thr_r, relax_lim_r};

  a_por_flag: assert property (@(posedge clock) disable iff (!rstn) srst |=> por_r && mode_r == 7'h09) // RULE_17
    else $error("soft reset did not restore");
  a_pin_hold: assert property (@(posedge clock) disable iff (!rstn) (chg_flag || volt_flag) |=> alarm_pin_oe) // RULE_25
    else $error("alarm pin released early");
  a_force_counting_method: assert property (@(posedge clock) disable iff (!rstn)
    wr_at(8'h00) && wd[5] && !srst |=> mode_r[5] ##1 (relax_r == 8'h00) && !mode_r[5]) // RULE_11
    else $error("force counting failed");
  a_force_voltage_method: assert property (@(posedge clock) disable iff (!rstn)
    wr_at(8'h00) && wd[6] && !wd[5] && !srst |=> ##1 relax_r == relax_lim_r) // RULE_12
    else $error("force voltage failed");
  a_count_clr: assert property (@(posedge clock) disable iff (!rstn) wr_at(8'h01) && wd[1] |=> cnt_r == 16'h0000) // RULE_14
    else $error("count not cleared");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn)
    bus_req.rd_re && !is_mapped(ptr_r) |=> rd_valid && rd_data == 8'h00) // RULE_29
    else $error("unmapped read not zero");
  a_ptr_step: assert property (@(posedge clock) disable iff (!rstn)
    !bus_req.addr_we && (bus_req.wr_we || bus_req.rd_re) |=> ptr_r == $past(ptr_r) + 8'h01) // RULE_28
    else $error("pointer did not step");
  a_standby_freeze: assert property (@(posedge clock) disable iff (!rstn)
    !operate && !srst && !wr_at(8'h01) |=> $stable(cnt_r) && $stable(cur_r)) // RULE_10
    else $error("standby not frozen");
  a_drive_low: assert property (@(posedge clock) disable iff (!rstn) !drive_r |=> alarm_pin_oe) // RULE_13
    else $error("pin not forced low");
endmodule

// ### bench/grb_host.sv
// host model issuing byte transactions to the register bank
`timescale 1ns/10ps
module grb_host
(
  input wire logic clock,
  output grb_pkg::grb_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial bus_req = '0;
  // start, address byte, then n data bytes high byte first
  task automatic op(input logic [7:0] a, input int n, input logic wr, input logic [15:0] wd,
                    output logic [15:0] q);
    q = '0;
    @(negedge clock);
    bus_req = '{1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
    @(negedge clock);
    bus_req = '{1'b0, 1'b1, 1'b0, 1'b0, a};
    for (int i = 0; i < n; i++)
    begin
      @(negedge clock);
      // a read answer stands one cycle after its strobe
      if (!wr && i > 0)
        q = {q[7:0], rd_valid ? rd_data : 8'hxx};
      bus_req = '{1'b0, 1'b0, wr, !wr, (i == n - 1) ? wd[7:0] : wd[15:8]};
    end
    @(negedge clock);
    if (!wr)
      q = {q[7:0], rd_valid ? rd_data : 8'hxx};
    bus_req = '0;
  endtask
endmodule

// ### bench/gauge_register_bank_tb.sv
// self-checking bench for the gauge register bank
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("ERROR %s exp %h got %h", n, e, a); end end
module gauge_register_bank_tb;
  localparam logic [7:0] PART = 8'h3c; // arbitrary value
  logic clock, rstn; // clock and active-low reset
  grb_pkg::grb_req_t bus_req; // host strobes
  logic [7:0] rd_data, lim; // read byte, random limit
  logic rd_valid, alarm_pin_o, alarm_pin_oe;
  grb_pkg::grb_meas_t meas; // datapath results
  grb_pkg::grb_ctl_t ctl; // mode controls out
  grb_pkg::grb_cfg_t cfg; // configuration out
  logic chg_c, volt_c, loss_e; // alarm causes
  wire logic pin_w = alarm_pin_oe ? alarm_pin_o : 1'b1; // pull-up on the open-drain pin
  int mismatches, total_checks, cyc;
  logic [15:0] v;
  logic [7:0] da [12] = '{8'h0f, 8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h30, 8'h04, 8'h0d, 8'h1b};
  int dn [12] = '{2, 2, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2};
  logic [15:0] dv [12] = '{16'h018b, 16'h0141, 16'h0002, 16'h00aa, 16'h000a, 16'h0078, 16'h0078, {8'h00, PART},
                           16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0] ra [6] = '{8'h18, 8'h16, 8'h1f, 8'h40, 8'hff, 8'h0a};
  grb_host host_u (.clock(clock), .bus_req(bus_req), .rd_data(rd_data), .rd_valid(rd_valid));
  grb_bank #(.PART_CODE(PART)) dut_u (.clock(clock), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .meas(meas), .low_charge_cond(chg_c), .low_voltage_cond(volt_c),
    .battery_loss_evt(loss_e), .alarm_pin_i(pin_w), .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe),
    .gauge_ctl(ctl), .gauge_cfg(cfg));
  // expected control byte from its fields
  function automatic logic [15:0] cx(logic pin, logic vm, logic bat, logic por, logic chg, logic vlt);
    return {9'h000, vlt, chg, por, bat, vm, 1'b0, pin};
  endfunction
  // read n bytes and compare
  task automatic ck(input string s, input logic [7:0] a, input int n, input logic [15:0] e);
    logic [15:0] q;
    host_u.op(a, n, 1'b0, 16'h0000, q);
    `CHK(s, e, q)
  endtask
  // write n bytes
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    logic [15:0] q;
    host_u.op(a, n, 1'b1, d, q);
  endtask
  // counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      give_verdict;
    end
  end
  initial
  begin
    void'($urandom(32'hc1e8));
    rstn = 1'b0;
    meas = '0;
    chg_c = 1'b0;
    volt_c = 1'b0;
    loss_e = 1'b0;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 12; i++)
      ck("default", da[i], dn[i], dv[i]);
    ck("mode", 8'h00, 1, 16'h0009);
    ck("ctrl", 8'h01, 1, cx(1, 0, 0, 1, 0, 0));
    `CHK("cfg rst", {16'h0000, 16'h018b, 16'h0141, 32'h02aa_0a78}, cfg)
    `CHK("ctl rst", 6'h28, ctl)
    $display("test defaults done");
    for (int i = 0; i < 16; i++)
    begin
      v = 16'($urandom);
      wr(8'h20 + 8'(i), v, 1);
      wr(8'h30 + 8'(i), ~v, 1);
      ck("ram", 8'h20 + 8'(i), 1, {8'h00, v[7:0]});
      ck("table", 8'h30 + 8'(i), 1, {8'h00, ~v[7:0]});
    end
    v = 16'($urandom);
    wr(8'h0d, v, 2);
    ck("ocv pair", 8'h0d, 2, v);
    ck("ocv high", 8'h0d, 1, {8'h00, v[15:8]});
    foreach (ra[i])
    begin
      wr(ra[i], 16'h00ff, 1);
      ck("read only", ra[i], 1, (i < 2) ? dv[7 - i] : 16'h0000);
    end
    wr(8'h00, 16'h0089, 1);
    ck("mode bit7", 8'h00, 1, 16'h0009);
    $display("test map done");
    wr(8'h00, 16'h0018, 1);
    lim = 8'($urandom);
    wr(8'h17, {8'h00, lim}, 1);
    wr(8'h00, 16'h0038, 1);
    repeat (2) @(negedge clock);
    ck("relax cc", 8'h16, 1, 16'h0000);
    ck("mode self", 8'h00, 1, 16'h0018);
    wr(8'h00, 16'h0058, 1);
    repeat (2) @(negedge clock);
    ck("relax vm", 8'h16, 1, {8'h00, lim});
    ck("mode self", 8'h00, 1, 16'h0018);
    $display("test force done");
    v = 16'($urandom);
    meas = '{1'b1, 1'b1, v, ~v, v ^ 16'h5a5a, v[15:8], v[7:0]};
    @(negedge clock);
    meas.update = 1'b0;
    ck("charge", 8'h02, 2, v);
    ck("current", 8'h06, 2, ~v);
    ck("voltage", 8'h08, 2, v ^ 16'h5a5a);
    ck("temp", 8'h0a, 1, {8'h00, v[15:8]});
    ck("count", 8'h04, 2, 16'h0001);
    ck("ctrl vm", 8'h01, 1, cx(1, 1, 0, 1, 0, 0));
    wr(8'h01, 16'h0003, 1);
    `CHK("ctl clr", 6'h19, ctl)
    ck("count clr", 8'h04, 2, 16'h0000);
    ck("ctrl por", 8'h01, 1, cx(1, 1, 0, 0, 0, 0));
    for (int k = 0; k < 2; k++)
    begin
      wr(k ? 8'h1d : 8'h1b, v | 16'h0001, 2);
      wr(k ? 8'h1a : 8'h19, 16'h00ff, 1);
      wr(8'h00, k ? 16'h001a : 16'h001c, 1);
      repeat (2) @(negedge clock);
      ck("accum", k ? 8'h1d : 8'h1b, 2, 16'h0000);
      ck("adjust", k ? 8'h1a : 8'h19, 1, 16'h0000);
      ck("mode clr", 8'h00, 1, 16'h0018);
    end
    $display("test measure done");
    chg_c = 1'b1;
    repeat (3) @(negedge clock);
    chg_c = 1'b0;
    volt_c = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("pin held", 1'b1, alarm_pin_oe)
    ck("alarms", 8'h01, 1, cx(0, 1, 0, 0, 1, 1));
    wr(8'h01, 16'h0041, 1);
    @(negedge clock);
    `CHK("one flag", 1'b1, alarm_pin_oe)
    wr(8'h01, 16'h0001, 1);
    repeat (2) @(negedge clock);
    `CHK("pin free", 1'b0, alarm_pin_oe)
    ck("flags clr", 8'h01, 1, cx(1, 1, 0, 0, 0, 0));
    volt_c = 1'b0;
    wr(8'h01, 16'h0000, 1);
    repeat (2) @(negedge clock);
    `CHK("pin forced", 1'b1, alarm_pin_oe)
    loss_e = 1'b1;
    @(negedge clock);
    loss_e = 1'b0;
    wr(8'h01, 16'h0009, 1);
    ck("loss", 8'h01, 1, cx(1, 1, 1, 0, 0, 0));
    wr(8'h01, 16'h0001, 1);
    ck("loss clr", 8'h01, 1, cx(1, 1, 0, 0, 0, 0));
    $display("test alarm done");
    wr(8'h20, 16'h005c, 1);
    wr(8'h01, 16'h0010, 1);
    ck("ram kept", 8'h20, 1, 16'h005c);
    ck("mode soft", 8'h00, 1, 16'h0009);
    ck("limit soft", 8'h17, 1, 16'h0078);
    ck("ctrl soft", 8'h01, 1, cx(1, 0, 0, 1, 0, 0));
    meas = '{1'b1, 1'b0, v, v, v, 8'h11, 8'h22};
    @(negedge clock);
    meas.update = 1'b0;
    ck("frozen", 8'h06, 2, 16'h0000);
    $display("test soft reset done");
    give_verdict;
  end
endmodule
